// file: shared/rca_pkg.sv
// constants, modes and carrier types for the receive comma word aligner
package rca_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // datapath geometry
   localparam int WORD_W = 40;
   localparam int SYM_W = 10;
   localparam int WIN_W = 80;
   localparam int PAIR_W = 20;
   localparam int OFF_W = 7;
   localparam logic [OFF_W-1:0] OFF_ZERO = 7'h00;
   localparam logic [OFF_W-1:0] OFF_ONE = 7'h01;
   localparam logic [OFF_W-1:0] SPAN_ONE_BYTE = 7'h0a;
   localparam logic [OFF_W-1:0] SPAN_TWO_BYTE = 7'h14;
   localparam logic [OFF_W-1:0] SPAN_FOUR_BYTE = 7'h28;
   localparam int OFF_COUNT = 40;

   ////////////////////////////////////////////////////////////////////////////
   // boundary granularity codes
   localparam logic [2:0] GRAN_ANY = 3'h1;
   localparam logic [2:0] GRAN_EVEN = 3'h2;
   localparam logic [2:0] GRAN_QUAD = 3'h4;

   // internal width select codes
   localparam logic INT_WIDTH_TWO_BYTE = 1'h0;
   localparam logic INT_WIDTH_FOUR_BYTE = 1'h1;

   ////////////////////////////////////////////////////////////////////////////
   // default comma patterns and mask, bit 0 received first
   localparam logic [SYM_W-1:0] MINUS_PATTERN_DEFAULT = 10'h283;
   localparam logic [SYM_W-1:0] PLUS_PATTERN_DEFAULT = 10'h17c;
   localparam logic [SYM_W-1:0] MATCH_MASK_DEFAULT = 10'h3ff;

   ////////////////////////////////////////////////////////////////////////////
   // slip control
   typedef enum logic [1:0] {
      SLIP_OFF,
      SLIP_LOGIC,
      SLIP_PHYSICAL,
      SLIP_AUTO
   } rca_slip_mode_type;

   localparam logic [1:0] SLIP_HOLD_CYCLES = 2'h2;
   localparam logic [5:0] SLIP_LOW_CYCLES = 6'h20;
   localparam logic [3:0] AUTO_SLIP_WAIT_DEFAULT = 4'h7;
   localparam logic [3:0] AUTO_WAIT_ZERO = 4'h0;
   localparam logic [3:0] AUTO_WAIT_ONE = 4'h1;

   typedef enum logic [0:0] {
      AUTO_CHECK,
      AUTO_WAIT
   } rca_auto_state_type;

   ////////////////////////////////////////////////////////////////////////////
   // static and slow configuration, all on the user clock
   typedef struct packed {
      logic comma_detect_enable;
      logic plus_align_enable;
      logic minus_align_enable;
      logic paired_select;
      logic plus_flag_select;
      logic minus_flag_select;
      logic show_realign;
      logic [2:0] granularity;
      logic internal_width_select;
      rca_slip_mode_type slip_mode_select;
      logic [3:0] auto_slip_wait;
      logic [SYM_W-1:0] plus_pattern;
      logic [SYM_W-1:0] minus_pattern;
      logic [SYM_W-1:0] match_mask;
   } rca_cfg_type;

endpackage

// file: hdl/rca_aligner.sv
// receive comma detection, byte/word alignment and bit slip for one lane
//
// Contract
// - two-cycle high request slips exactly one bit
// - active slip request overrides comma alignment
// - logic-layer slip left, wraps, clock unchanged
// - logic-layer slip range is the boundary span, reaching 40 bits only at four-byte boundaries
// - physical slip right, clock shifts alternate slips
// - modes off, logic, physical, auto ignoring request
// - auto slip waits programmable 1..15 cycles, a setting of 0 waits 1
// - aligned flag set only by enabled polarities
// - realign flag marks comma-driven alignment change
// - comma seen flag comes in the same cycle as the comma data
// - detect enable low bypasses the aligner
// - granularity one, two, four byte boundaries
// - ten-bit mask makes pattern bits don't-care
// - paired mode needs plus then minus
// - ten-bit patterns, bit 0 first, defaults
// - flag selects gate comma seen, not alignment
// - pass-through off drops the realigning comma
// - misplaced enabled comma realigns, one-cycle pulse
// - misplaced comma, alignment off, drops aligned flag
// - seven-bit status shows current alignment offset
`timescale 1ns/1ps

module rca_aligner (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // deserializer side
   input wire logic [rca_pkg::WORD_W-1:0] deser_word,
   // configuration
   input wire rca_pkg::rca_cfg_type cfg,
   // user side controls
   input wire logic bit_slip_request,
   // user side data and status
   output logic [rca_pkg::WORD_W-1:0] received_word,
   output logic received_valid,
   output logic byte_aligned_flag,
   output logic realign_flag,
   output logic comma_seen_flag,
   output logic [rca_pkg::OFF_W-1:0] current_align_offset_status,
   // recovered clock phase step, one pulse per 2 UI shift
   output logic recovered_clock_shift
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // masked pattern compare
   function automatic logic match_sym(input logic [rca_pkg::SYM_W-1:0] data,
                                      input logic [rca_pkg::SYM_W-1:0] pattern,
                                      input logic [rca_pkg::SYM_W-1:0] mask);
      match_sym = ((data ^ pattern) & mask) == '0;
   endfunction

   // position of a bit offset within the current alignment span
   function automatic logic [rca_pkg::OFF_W-1:0] mod_span(input logic [rca_pkg::OFF_W-1:0] value,
                                                          input logic [rca_pkg::OFF_W-1:0] span);
      logic [rca_pkg::OFF_W-1:0] rest;
      rest = value;
      if (rest >= span) begin
         rest = rest - span;
      end
      if (rest >= span) begin
         rest = rest - span;
      end
      if (rest >= span) begin
         rest = rest - span;
      end
      mod_span = rest;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [rca_pkg::WORD_W-1:0] prev_word;
   logic [rca_pkg::WORD_W-1:0] cur_word;
   logic [rca_pkg::WIN_W-1:0] window;
   logic [rca_pkg::WIN_W-1:0] shifted;
   logic [rca_pkg::OFF_W-1:0] span;
   logic [rca_pkg::OFF_W-1:0] align_offset;
   logic [rca_pkg::OFF_W-1:0] next_align_offset;
   logic hit_found;
   logic hit_plus;
   logic hit_minus;
   logic [rca_pkg::OFF_W-1:0] hit_off;
   logic hit_align_en;
   logic hit_placed;
   logic comma_realign;
   logic next_aligned;
   logic manual_mode;
   logic slip_override;
   logic [1:0] slip_hi_cnt;
   logic slip_armed;
   logic manual_fire;
   logic auto_fire;
   logic slip_fire;
   logic slip_right;
   logic slip_parity;
   rca_pkg::rca_auto_state_type auto_state;
   logic [3:0] auto_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // input staging and alignment span

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_word <= '0;
         cur_word <= '0;
      end else begin
         prev_word <= cur_word;
         cur_word <= deser_word;
      end
   end

   // older word in the low half so bit 0 is the earliest received
   assign window = {cur_word, prev_word};
   assign shifted = window >> align_offset;

   // quad granularity with two-byte width is not legal; fall back to even
   always_comb begin
      case (cfg.granularity)
         rca_pkg::GRAN_ANY: span = rca_pkg::SPAN_ONE_BYTE;
         rca_pkg::GRAN_EVEN: span = rca_pkg::SPAN_TWO_BYTE;
         rca_pkg::GRAN_QUAD: begin
            if (cfg.internal_width_select == rca_pkg::INT_WIDTH_FOUR_BYTE) begin
               span = rca_pkg::SPAN_FOUR_BYTE;
            end else begin
               span = rca_pkg::SPAN_TWO_BYTE;
            end
         end
         default: span = rca_pkg::SPAN_ONE_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // comma search over every bit offset, lowest offset wins

   always_comb begin
      logic p;
      logic m;
      logic pm;
      p = 1'b0;
      m = 1'b0;
      pm = 1'b0;
      hit_found = 1'b0;
      hit_plus = 1'b0;
      hit_minus = 1'b0;
      hit_off = rca_pkg::OFF_ZERO;
      for (int i = rca_pkg::OFF_COUNT - 1; i >= 0; i--) begin
         p = match_sym(window[i +: rca_pkg::SYM_W], cfg.plus_pattern, cfg.match_mask);
         m = match_sym(window[i +: rca_pkg::SYM_W], cfg.minus_pattern, cfg.match_mask);
         if (cfg.paired_select) begin
            // plus first, minus directly after it
            pm = p & match_sym(window[i + rca_pkg::SYM_W +: rca_pkg::SYM_W], cfg.minus_pattern,
                               cfg.match_mask);
            p = pm;
            m = pm;
         end
         if (p | m) begin
            hit_found = 1'b1;
            hit_plus = p;
            hit_minus = m;
            hit_off = i[rca_pkg::OFF_W-1:0];
         end
      end
   end

   // alignment only reacts to polarities whose enable is set
   assign hit_align_en = (hit_plus & cfg.plus_align_enable) | (hit_minus & cfg.minus_align_enable);
   assign hit_placed = mod_span(hit_off, span) == align_offset;

   ////////////////////////////////////////////////////////////////////////////
   // manual slip request qualification

   assign manual_mode = (cfg.slip_mode_select == rca_pkg::SLIP_LOGIC) ||
                        (cfg.slip_mode_select == rca_pkg::SLIP_PHYSICAL);
   assign slip_override = manual_mode & bit_slip_request;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slip_hi_cnt <= '0;
         slip_armed <= 1'b1;
      end else if (!bit_slip_request) begin
         // rearm once released; the user keeps the low gap long enough
         slip_hi_cnt <= '0;
         slip_armed <= 1'b1;
      end else begin
         if (slip_hi_cnt != rca_pkg::SLIP_HOLD_CYCLES) begin
            slip_hi_cnt <= slip_hi_cnt + 2'h1;
         end
         // one adjustment per assertion, however long the request stays high
         if (manual_fire) begin
            slip_armed <= 1'b0;
         end
      end
   end

   // fires once, on the second high cycle of an assertion
   assign manual_fire = manual_mode & bit_slip_request & slip_armed &
                        (slip_hi_cnt == rca_pkg::SLIP_HOLD_CYCLES - 2'h1);

   ////////////////////////////////////////////////////////////////////////////
   // automatic slip: slip while unaligned, then wait before checking again

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         auto_state <= rca_pkg::AUTO_CHECK;
         auto_cnt <= rca_pkg::AUTO_WAIT_ZERO;
      end else begin
         case (auto_state)
            rca_pkg::AUTO_CHECK: begin
               if (auto_fire) begin
                  auto_state <= rca_pkg::AUTO_WAIT;
                  auto_cnt <= cfg.auto_slip_wait;
               end
            end
            rca_pkg::AUTO_WAIT: begin
               if (auto_cnt <= rca_pkg::AUTO_WAIT_ONE) begin
                  auto_state <= rca_pkg::AUTO_CHECK;
                  auto_cnt <= rca_pkg::AUTO_WAIT_ZERO;
               end else begin
                  auto_cnt <= auto_cnt - rca_pkg::AUTO_WAIT_ONE;
               end
            end
            default: begin
               auto_state <= rca_pkg::AUTO_CHECK;
               auto_cnt <= rca_pkg::AUTO_WAIT_ZERO;
            end
         endcase
      end
   end

   // the request pin plays no part in the automatic mode
   assign auto_fire = (cfg.slip_mode_select == rca_pkg::SLIP_AUTO) && (auto_state == rca_pkg::AUTO_CHECK) &&
                      cfg.comma_detect_enable && !byte_aligned_flag && !hit_found;
   assign slip_fire = manual_fire | auto_fire;
   assign slip_right = cfg.slip_mode_select != rca_pkg::SLIP_LOGIC;

   ////////////////////////////////////////////////////////////////////////////
   // alignment offset: slip first, then comma alignment

   assign comma_realign = cfg.comma_detect_enable & !slip_override & hit_found & hit_align_en &
                          !hit_placed;

   always_comb begin
      next_align_offset = align_offset;
      if (slip_fire) begin
         if (slip_right) begin
            // right by one, wrapping within the span
            if (align_offset == rca_pkg::OFF_ZERO) begin
               next_align_offset = span - rca_pkg::OFF_ONE;
            end else begin
               next_align_offset = align_offset - rca_pkg::OFF_ONE;
            end
         end else begin
            // left by one, wrapping within the span
            if (align_offset + rca_pkg::OFF_ONE >= span) begin
               next_align_offset = rca_pkg::OFF_ZERO;
            end else begin
               next_align_offset = align_offset + rca_pkg::OFF_ONE;
            end
         end
      end else if (comma_realign) begin
         next_align_offset = mod_span(hit_off, span);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         align_offset <= rca_pkg::OFF_ZERO;
      end else begin
         align_offset <= next_align_offset;
      end
   end

   // phase of the recovered clock moves on every second right slip
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slip_parity <= 1'b0;
         recovered_clock_shift <= 1'b0;
      end else begin
         recovered_clock_shift <= slip_fire & slip_right & slip_parity;
         if (slip_fire & slip_right) begin
            slip_parity <= !slip_parity;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // alignment status

   always_comb begin
      next_aligned = byte_aligned_flag;
      if (!cfg.comma_detect_enable) begin
         next_aligned = 1'b0;
      end else if (slip_fire) begin
         next_aligned = 1'b0;
      end else if (!slip_override && hit_found) begin
         if (hit_align_en) begin
            next_aligned = 1'b1;
         end else if (!hit_placed) begin
            next_aligned = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         byte_aligned_flag <= 1'b0;
         realign_flag <= 1'b0;
         comma_seen_flag <= 1'b0;
      end else begin
         byte_aligned_flag <= next_aligned;
         realign_flag <= comma_realign;
         // flag selects gate only the comma seen flag
         comma_seen_flag <= cfg.comma_detect_enable & hit_found &
                            ((hit_plus & cfg.plus_flag_select) | (hit_minus & cfg.minus_flag_select));
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         current_align_offset_status <= rca_pkg::OFF_ZERO;
      end else begin
         current_align_offset_status <= next_align_offset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // parallel output

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         received_word <= '0;
         received_valid <= 1'b0;
      end else if (!cfg.comma_detect_enable) begin
         received_word <= cur_word;
         received_valid <= 1'b1;
      end else begin
         received_word <= shifted[rca_pkg::WORD_W-1:0];
         // the comma that forced a realignment is withheld unless shown
         received_valid <= !(comma_realign & !cfg.show_realign);
      end
   end

endmodule

// file: bench/rca_user_model.sv
// user-side model issuing bit slip requests with legal hold and gap
`timescale 1ns/1ps
module rca_user_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command from the bench
   input wire logic go,
   input wire logic [1:0] extra,
   // towards the aligner and the bench
   output logic bit_slip_request,
   output logic busy
);
   logic [5:0] cnt;
   assign busy = cnt != 6'h00;
   // high for two cycles plus extra, then low for 35 cycles at least
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 6'h00;
         bit_slip_request <= 1'b0;
      end else if (busy) begin
         cnt <= cnt - 6'h01;
         bit_slip_request <= cnt > 6'h23;
      end else if (go) begin
         cnt <= 6'h24 + 6'(extra);
         bit_slip_request <= 1'b1;
      end
   end
endmodule

// file: bench/rca_aligner_properties.sv
// port assertions for the comma word aligner
`timescale 1ns/1ps
module rca_aligner_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // configuration and request
   input wire rca_pkg::rca_cfg_type cfg,
   input wire logic bit_slip_request,
   // status outputs
   input wire logic received_valid,
   input wire logic byte_aligned_flag,
   input wire logic realign_flag,
   input wire logic comma_seen_flag,
   input wire logic [rca_pkg::OFF_W-1:0] current_align_offset_status,
   input wire logic recovered_clock_shift
);
   logic [rca_pkg::OFF_W-1:0] st;
   logic [rca_pkg::OFF_W-1:0] span;
   logic req;
   rca_pkg::rca_slip_mode_type md;
   assign st = current_align_offset_status;
   assign req = bit_slip_request;
   assign md = cfg.slip_mode_select;
   // wrap span of the offset for the boundary setting
   assign span = (cfg.granularity == rca_pkg::GRAN_QUAD && cfg.internal_width_select) ? 7'h28 :
      (cfg.granularity inside {rca_pkg::GRAN_EVEN, rca_pkg::GRAN_QUAD}) ? 7'h14 : 7'h0a;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   a_realign_one_pulse: assert property (realign_flag |=> !realign_flag)
      else $error("realign pulse too long");
   a_realign_sets_aligned: assert property (realign_flag |-> byte_aligned_flag)
      else $error("realign without aligned");
   a_bypass_quiet: assert property (
      !cfg.comma_detect_enable [*2] |-> !realign_flag && !comma_seen_flag)
      else $error("flags in bypass");
   a_hidden_comma: assert property (realign_flag && !cfg.show_realign |-> !received_valid)
      else $error("realign comma shown");
   a_offset_in_span: assert property (st < span)
      else $error("offset beyond span");
   a_logic_step: assert property (
      !req ##1 (req && md == rca_pkg::SLIP_LOGIC) [*2] |=> st == ($past(st) + 7'h01) % span)
      else $error("left slip wrong");
   a_phys_step: assert property (
      !req ##1 (req && md == rca_pkg::SLIP_PHYSICAL) [*2] |=> st == (($past(st) == 7'h00) ? span : $past(st)) - 7'h01)
      else $error("right slip wrong");
   a_single_slip: assert property (
      (req && md inside {rca_pkg::SLIP_LOGIC, rca_pkg::SLIP_PHYSICAL}) [*3] |=> $stable(st))
      else $error("extra slip");
   a_logic_no_shift: assert property (md == rca_pkg::SLIP_LOGIC |-> !recovered_clock_shift)
      else $error("clock moved in logic mode");
   a_shift_cause: assert property (
      recovered_clock_shift |-> $changed(st) && md inside {rca_pkg::SLIP_PHYSICAL, rca_pkg::SLIP_AUTO})
      else $error("stray clock shift");
   a_off_holds: assert property (md == rca_pkg::SLIP_OFF && !realign_flag |-> $stable(st))
      else $error("offset moved in off mode");
   a_seen_gated: assert property (comma_seen_flag |-> cfg.plus_flag_select || cfg.minus_flag_select)
      else $error("comma seen ungated");
   c_realign: cover property (realign_flag);
   c_phase_step: cover property (recovered_clock_shift);
   c_bypass: cover property (!cfg.comma_detect_enable && received_valid);
   c_auto_slip: cover property (md == rca_pkg::SLIP_AUTO && $changed(st));
endmodule

bind rca_aligner rca_aligner_checker chk (.clk(clk), .rst(rst), .cfg(cfg), .bit_slip_request(bit_slip_request),
   .received_valid(received_valid), .byte_aligned_flag(byte_aligned_flag), .realign_flag(realign_flag),
   .comma_seen_flag(comma_seen_flag), .current_align_offset_status(current_align_offset_status),
   .recovered_clock_shift(recovered_clock_shift));

// file: bench/tb.sv
// self-checking bench for the receive comma word aligner
`timescale 1ns/1ps
module tb;
   typedef logic [rca_pkg::WORD_W-1:0] rca_word_type;
   logic clk;
   logic rst;
   rca_word_type deser_word;
   rca_pkg::rca_cfg_type cfg;
   logic bit_slip_request;
   rca_word_type received_word;
   logic received_valid;
   logic byte_aligned_flag;
   logic realign_flag;
   logic comma_seen_flag;
   logic [rca_pkg::OFF_W-1:0] current_align_offset_status;
   logic recovered_clock_shift;
   logic go;
   logic [1:0] extra;
   logic busy;
   int n_errors;
   int samples_checked;
   int nr;
   int ns;
   int nk;

   rca_aligner dut (.clk(clk), .rst(rst), .deser_word(deser_word), .cfg(cfg), .bit_slip_request(bit_slip_request),
      .received_word(received_word), .received_valid(received_valid), .byte_aligned_flag(byte_aligned_flag),
      .realign_flag(realign_flag), .comma_seen_flag(comma_seen_flag),
      .current_align_offset_status(current_align_offset_status), .recovered_clock_shift(recovered_clock_shift));
   rca_user_model usr (.clk(clk), .rst(rst), .go(go), .extra(extra), .bit_slip_request(bit_slip_request),
      .busy(busy));

   ////////////////////////////////////////////////////////////
   function automatic rca_word_type rot(input rca_word_type x, input int s);
      logic [2*rca_pkg::WORD_W-1:0] w;
      w = {x, x} >> s;
      return w[rca_pkg::WORD_W-1:0];
   endfunction
   function automatic logic [6:0] span(input logic [2:0] g);
      return (g == 3'h4) ? 7'h28 : (g == 3'h2) ? 7'h14 : 7'h0a;
   endfunction
   task automatic chk_v(input rca_word_type g, input rca_word_type e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_n(input int g, input int e);
      samples_checked++;
      if (g != e) begin
         n_errors++;
         $display("BAD at %0t: count %0d want %0d", $time, g, e);
      end
   endtask
   task automatic run(input int n);
      repeat (n) begin
         @(negedge clk);
         nr += int'(realign_flag === 1'b1);
         ns += int'(comma_seen_flag === 1'b1);
         nk += int'(recovered_clock_shift === 1'b1);
      end
   endtask
   task automatic restart(input rca_pkg::rca_cfg_type c, input rca_word_type p);
      @(posedge clk);
      rst <= 1'b1;
      cfg <= c;
      deser_word <= p;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      nr = 0;
      ns = 0;
      nk = 0;
   endtask
   task automatic give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (4000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   initial begin
      rca_pkg::rca_cfg_type b;
      rca_pkg::rca_cfg_type c;
      rca_word_type p;
      logic [6:0] e;
      logic pe;
      logic me;
      logic fs;
      logic h;
      int k;
      int o;
      rst = 1'b1;
      cfg = '0;
      deser_word = '0;
      go = 1'b0;
      extra = 2'h0;
      n_errors = 0;
      samples_checked = 0;
      void'($urandom(90));
      b = '0;
      b.comma_detect_enable = 1'b1;
      b.internal_width_select = rca_pkg::INT_WIDTH_FOUR_BYTE;
      b.auto_slip_wait = rca_pkg::AUTO_SLIP_WAIT_DEFAULT;
      b.plus_pattern = rca_pkg::PLUS_PATTERN_DEFAULT;
      b.minus_pattern = rca_pkg::MINUS_PATTERN_DEFAULT;
      b.match_mask = rca_pkg::MATCH_MASK_DEFAULT;
      chk_v({b.minus_pattern, b.plus_pattern}, {10'h283, 10'h17c});
      c = b;
      c.comma_detect_enable = 1'b0;
      p = rca_word_type'({$urandom, $urandom});
      restart(c, p);
      run(6);
      chk_v(received_word, p);
      chk_v(received_valid, 1'b1);
      chk_n(nr + ns, 0);
      $display("bypass test done");
      // kinds: plus, minus, plus then minus paired, lone plus in paired mode
      for (int i = 0; i < 12; i++) begin
         k = $urandom % 4;
         o = ($urandom % 20) * 2 + 1;
         pe = 1'($urandom);
         me = (k > 1) ? pe : 1'($urandom);
         fs = 1'($urandom);
         c = b;
         c.granularity = 3'(1 << ($urandom % 3));
         c.paired_select = (k > 1);
         c.plus_align_enable = pe;
         c.minus_align_enable = me;
         c.plus_flag_select = fs;
         c.minus_flag_select = fs;
         p = rca_word_type'(k == 1 ? b.minus_pattern : k == 2 ? {b.minus_pattern, b.plus_pattern} : b.plus_pattern);
         p = rot(p, 40 - o);
         h = (k == 1) ? me : (k != 3 && pe);
         e = h ? 7'(o % span(c.granularity)) : 7'h00;
         restart(c, p);
         run(10);
         chk_n(nr, h);
         chk_n(ns > 0, fs && k != 3);
         chk_v(byte_aligned_flag, h);
         chk_v(current_align_offset_status, e);
         chk_v(received_word, rot(p, e));
      end
      $display("align test done");
      for (int j = 0; j < 3; j++) begin
         c = b;
         c.granularity = 3'(1 << ($urandom % 3));
         c.slip_mode_select = (j == 0) ? rca_pkg::SLIP_LOGIC : (j == 1) ? rca_pkg::SLIP_PHYSICAL : rca_pkg::SLIP_OFF;
         p = rca_word_type'({$urandom, $urandom});
         e = 7'h00;
         restart(c, p);
         for (int s = 0; s < 11; s++) begin
            @(posedge clk);
            go <= 1'b1;
            extra <= 2'($urandom);
            @(posedge clk);
            go <= 1'b0;
            run(2);
            for (int t = 0; t < 60 && busy !== 1'b0; t++)
               run(1);
            if (j == 0) e = (e + 7'h01) % span(c.granularity);
            else if (j == 1) e = ((e == 7'h00) ? span(c.granularity) : e) - 7'h01;
            chk_v(current_align_offset_status, e);
         end
         run(4);
         chk_v(received_word, rot(p, e));
         chk_n(nk, (j == 1) ? 5 : 0);
      end
      $display("slip test done");
      // automatic mode on a comma-free stream; the request pulse must be ignored
      c = b;
      c.granularity = 3'(1 << ($urandom % 3));
      c.slip_mode_select = rca_pkg::SLIP_AUTO; // elastic buffer taken as in use
      c.auto_slip_wait = 4'($urandom);
      restart(c, rca_word_type'({4{10'h2aa}}));
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      run(99);
      o = (c.auto_slip_wait == rca_pkg::AUTO_WAIT_ZERO) ? 2 : int'(c.auto_slip_wait) + 1;
      k = 98 / o + 1;
      e = 7'((span(c.granularity) - k % span(c.granularity)) % span(c.granularity));
      chk_v(current_align_offset_status, e);
      chk_n(nk, k / 2);
      $display("auto test done");
      give_verdict();
   end
endmodule
